// >>> gpx_board.sv
// Board model on the port pins: external drivers, pulls and floating lines.
// Assumes the block's pin outputs and one clock; the bench picks external drive.
`timescale 1ns/1ps
module gpx_board (
   input wire clk_i,
   input wire [47:0] pin_out_i,
   input wire [47:0] pin_oen_i,
   input wire [47:0] pin_pu_i,
   input wire [47:0] pin_pd_i,
   input wire [47:0] ext_en_i,
   input wire [47:0] ext_val_i,
   output wire [47:0] pin_o
);
   // ==========
   // Port 2 pins 4 and 6 never driven high by the board's external drivers
   localparam [47:0] KEEP_LOW = 48'h000000500000;
   reg [47:0] last_r = 48'h0;
   wire [47:0] ext = ext_val_i & ~KEEP_LOW;
   // External drive wins; a bare line floats to the inverse of its last level
   assign pin_o = (ext_en_i & ext) | (~ext_en_i & ~pin_oen_i & pin_out_i) |
      (~ext_en_i & pin_oen_i & (pin_pu_i | (~pin_pd_i & ~last_r)));
   // Last level, so a floating line never shows a stable value
   always @(posedge clk_i) begin
      last_r <= pin_o;
   end
endmodule

// >>> gpx_chk_asserts.sv
// Assertions on the ports of the GPIO port block.
// Assumes one clock and an active-low reset; bound into gpx_top at the foot.
`timescale 1ns/1ps
module gpx_chk #(
   parameter PIN_HOLD_CYC = 20,
   parameter CPU_HOLD_CYC = 40
) (
   input wire clk_i,
   input wire rstn_i,
   input wire por_reset_i,
   input wire hsel_i,
   input wire [31:0] haddr_i,
   input wire [1:0] htrans_i,
   input wire hwrite_i,
   input wire hready_i,
   input wire hreadyout_o,
   input wire hresp_o,
   input wire [31:0] hrdata_o,
   input wire [47:0] pin_out_o,
   input wire [47:0] pin_oen_o,
   input wire [47:0] pin_pullup_o,
   input wire [47:0] pin_pulldown_o,
   input wire pin_irq_o,
   input wire cpu_hold_o
);
   // ==========
   // Cycles since reset release; saturates so long runs stay quiet
   reg [7:0] cnt_r;
   reg por_r;
   wire rd_acc = hsel_i & htrans_i[1] & hready_i & ~hwrite_i;
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_r <= 8'h00;
         por_r <= 1'b1;
      end else begin
         if (cnt_r == 8'h00) begin
            por_r <= por_reset_i;
         end
         if (cnt_r != 8'hff) begin
            cnt_r <= cnt_r + 8'h01;
         end
      end
   end
   // ==========
   // Properties
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   sequence s_rd(idx);
      rd_acc && haddr_i[8:2] == idx;
   endsequence
   a_bus_okay: assert property (hreadyout_o && !hresp_o)
      else $error("bus answer not okay");
   a_hold_low: assert property (cnt_r >= 2 && cnt_r < PIN_HOLD_CYC |-> !pin_oen_o[8] && !pin_out_o[8])
      else $error("held pin not driven low");
   a_narrow_off: assert property (pin_oen_o[47:44] == 4'hf)
      else $error("missing pins driven");
   a_rdata_stable: assert property (!rd_acc |=> $stable(hrdata_o))
      else $error("read data moved");
   a_cpu_hold: assert property (cnt_r >= 2 && cnt_r < CPU_HOLD_CYC |-> cpu_hold_o == por_r)
      else $error("cpu hold wrong");
   a_cpu_free: assert property (cnt_r > CPU_HOLD_CYC + 1 |-> !cpu_hold_o)
      else $error("cpu hold too long");
   a_pull_hiz: assert property (((pin_pullup_o | pin_pulldown_o) & ~pin_oen_o) == 48'h0)
      else $error("pull with strong drive");
   a_status_rd: assert property (s_rd(7'h18) |=> hrdata_o[31:1] == {29'h0, $past(pin_irq_o), $past(cpu_hold_o)})
      else $error("status read wrong");
   a_narrow_rd: assert property (s_rd(7'h14) |=> hrdata_o[31:4] == 28'h0)
      else $error("narrow port upper bits set");
endmodule
bind gpx_top gpx_chk #(.PIN_HOLD_CYC(PIN_HOLD_CYC), .CPU_HOLD_CYC(CPU_HOLD_CYC)) u_chk (.clk_i(clk_i),
   .rstn_i(rstn_i), .por_reset_i(por_reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
   .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
   .hrdata_o(hrdata_o), .pin_out_o(pin_out_o), .pin_oen_o(pin_oen_o), .pin_pullup_o(pin_pullup_o),
   .pin_pulldown_o(pin_pulldown_o), .pin_irq_o(pin_irq_o), .cpu_hold_o(cpu_hold_o));

// >>> gpx_hold_timer.v
// One-shot hold timer: busy from reset until CYCLES clock edges have passed.
// Assumes one clock; cancel_i sampled on each edge ends the hold at once.
`timescale 1ns/1ps

module gpx_hold_timer #(
   parameter CNT_W = 24,
   parameter CYCLES = 16
) (
   input wire clk_i,
   input wire rstn_i,
   input wire cancel_i,
   output wire busy_o
);
   // Terminal count cut to the counter width on purpose; CYCLES must fit CNT_W bits
   localparam [31:0] LAST_FULL = CYCLES - 1;
   localparam [CNT_W-1:0] LAST = LAST_FULL[CNT_W-1:0];

   reg busy_r;
   reg [CNT_W-1:0] cnt_r;

   // ==========================================================
   // Counter
   // Busy is a reset constant, so the hold starts with the release itself
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         busy_r <= 1'b1;
         cnt_r <= {CNT_W{1'b0}};
      end else if (busy_r) begin
         if (cancel_i || cnt_r == LAST) begin
            busy_r <= 1'b0;
         end else begin
            cnt_r <= cnt_r + 1'b1;
         end
      end
   end

   assign busy_o = busy_r;
endmodule

// >>> gpx_map.vh
// Address map, field codes, reset values and timing counts of the GPIO port block.
// Assumes the includer works on a 200 MHz clock and a 32-bit AHB-Lite register bus.
`ifndef GPX_MAP_VH
`define GPX_MAP_VH

// ==========================================================
// Port geometry
`define GPX_NPORT 6
`define GPX_PORT_W 8
`define GPX_NPIN 48
`define GPX_NARROW_W 4
`define GPX_GLB_W 8
// Pins that exist: the narrow port carries only its low four bits
`define GPX_PIN_MASK 48'h0fffffffffff
// Pin held low after an external reset: port 1 bit 0
`define GPX_HOLD_PIN 8

// ==========================================================
// Register indices, byte address is four times the index
// Bank 0 per port: index = port*4 + kind
`define GPX_K0_DATA 2'h0
`define GPX_K0_INTEN 2'h1
`define GPX_K0_GLBSEL 2'h2
// Bank 1 per port: index = port*4 + kind
`define GPX_K1_DRV_LO 2'h0
`define GPX_K1_DRV_HI 2'h1
`define GPX_K1_INTCTL0 2'h2
`define GPX_K1_INTCTL1 2'h3
// Index constant 0x20 (byte 0x080), not used by the decode; bank 1 is picked by byte address bit 8
`define GPX_BANK1_BASE 6'h20
// Status register index (read only)
`define GPX_IDX_STATUS 6'h18
`define GPX_ST_PIN_HOLD 0
`define GPX_ST_CPU_HOLD 1
`define GPX_ST_IRQ 2

// ==========================================================
// Field codes and reset values
`define GPX_REG_RST 8'h00
`define GPX_DM_HIZ 2'h2
`define GPX_IM_CHANGE 2'h0
`define GPX_IM_RISE 2'h1
`define GPX_IM_FALL 2'h2
`define GPX_IM_BOTH 2'h3

// ==========================================================
// Timing
`define GPX_CLK_KHZ 200000
`define GPX_PIN_HOLD_MS 16
`define GPX_CPU_HOLD_MS 64
`define GPX_PIN_HOLD_CYC (`GPX_PIN_HOLD_MS * `GPX_CLK_KHZ)
`define GPX_CPU_HOLD_CYC (`GPX_CPU_HOLD_MS * `GPX_CLK_KHZ)
`define GPX_CNT_W 24

`endif

// >>> gpx_top.v
// GPIO ports: five 8-bit ports and one 4-bit port behind an AHB-Lite slave.
// Assumes pins and bus are synchronous to clk_i; external pads resolve drive and pulls.
//
// Summary of operation
// - Five 8-bit ports plus one 4-bit port.
// - CPU reads every pin's live level.
// - CPU-written data bit drives its pin.
// - Direction set per bit, independently.
// - Every bit may join global input/output busses.
// - Interrupt on rise, fall or change-from-read.
// - Drive per level: strong, resistive, or high-Z.
// - Port 1 bit 0 held low after reset.
// - Writes during hold stored, applied afterwards.
// - Held pin still inputs and stays configurable.
// - Power-on reset holds CPU about 64 ms.
// - Data write sets outputs; read returns pins.
// - Write-only interrupt enable, one bit per pin.
// - Global select: high-Z drives input, else receives.
// - Drive-mode pair decode, four documented combinations.
`timescale 1ns/1ps
`include "gpx_map.vh"

module gpx_top #(
   parameter PIN_HOLD_CYC = `GPX_PIN_HOLD_CYC,
   parameter CPU_HOLD_CYC = `GPX_CPU_HOLD_CYC
) (
   input wire clk_i,
   input wire rstn_i,
   input wire por_reset_i,
   // AHB-Lite slave
   input wire hsel_i,
   input wire [31:0] haddr_i,
   input wire [1:0] htrans_i,
   input wire hwrite_i,
   input wire [2:0] hsize_i,
   input wire [31:0] hwdata_i,
   input wire hready_i,
   output wire hreadyout_o,
   output wire hresp_o,
   output reg [31:0] hrdata_o,
   // Pins
   input wire [`GPX_NPIN-1:0] pin_in_i,
   output reg [`GPX_NPIN-1:0] pin_out_o,
   output reg [`GPX_NPIN-1:0] pin_oen_o,
   output reg [`GPX_NPIN-1:0] pin_pullup_o,
   output reg [`GPX_NPIN-1:0] pin_pulldown_o,
   // Global busses
   input wire [`GPX_GLB_W-1:0] glb_out_i,
   output reg [`GPX_GLB_W-1:0] glb_in_o,
   // Toward interrupt controller and CPU
   output reg pin_irq_o,
   output wire cpu_hold_o
);

   // ==========================================================
   // Register map, one aligned word per register, byte data in bits 7:0
   //   Bank 0, byte 0x000 + port * 16 + kind * 4:
   //     kind 0: port data; a write sets outputs, a read returns pin levels
   //     kind 1: interrupt enable, write only
   //     kind 2: global bus connect, write only
   //     kind 3: reserved
   //   Bank 1, byte 0x100 + port * 16 + kind * 4:
   //     kind 0: drive select low bit, write only
   //     kind 1: drive select high bit, write only
   //     kind 2: interrupt mode low bit, write only
   //     kind 3: interrupt mode high bit, write only
   //   Status, byte 0x060, read only: bit 0 pin hold, bit 1 CPU hold, bit 2 request
   // Misses and write-only registers read zero; every answer is OKAY with no wait
   //
   // Bus timing:
   //   write: register updates at the data-phase edge, pad outputs one edge later
   //   read: pins sampled at the address-phase edge, data stand in the data phase
   // Limitation: the narrow port stores eight bits but only four reach pads

   // ==========================================================
   // Decoding helpers
   // Split a word index into {invalid, bank, port, kind}
   // The invalid flag stands alone so that bank 1 is never taken for a miss
   function [6:0] idx_decode;
      input [8:2] addr;
      reg bank;
      reg [5:0] idx;
      begin
         bank = addr[8];
         idx = addr[7:2];
         idx_decode = {1'b0, bank, idx[4:2], idx[1:0]};
         if (idx[5] || idx[4:2] > 3'd5) begin
            idx_decode = 7'h7f;
         end
      end
   endfunction

   // Drive decode: {strong, pullup, pulldown} for a mode and a level
   // Strong turns the output enable low; the two pulls are resistive and exclusive
   function [2:0] drv_decode;
      input [1:0] dm;
      input d;
      begin
         case (dm)
            2'h0: drv_decode = d ? 3'b100 : 3'b001;
            2'h1: drv_decode = 3'b100;
            2'h2: drv_decode = 3'b000;
            2'h3: drv_decode = d ? 3'b010 : 3'b100;
            default: drv_decode = 3'b000;
         endcase
      end
   endfunction

   // ==========================================================
   // Register state, flat over all pins, 8 bits per port
   reg [`GPX_NPIN-1:0] data_r;
   reg [`GPX_NPIN-1:0] inten_r;
   reg [`GPX_NPIN-1:0] glbsel_r;
   reg [`GPX_NPIN-1:0] drv_lo_r;
   reg [`GPX_NPIN-1:0] drv_hi_r;
   reg [`GPX_NPIN-1:0] intctl0_r;
   reg [`GPX_NPIN-1:0] intctl1_r;
   reg [`GPX_NPIN-1:0] last_rd_r;
   reg [`GPX_NPIN-1:0] prev_pin_r;

   // Bus address-phase capture
   reg wr_pend_r;
   reg [6:0] wr_dec_r;

   wire [`GPX_NPIN-1:0] pins = pin_in_i & `GPX_PIN_MASK;
   wire acc = hsel_i && htrans_i[1] && hready_i;
   wire [6:0] dec_now = idx_decode(haddr_i[8:2]);
   wire stat_hit = !haddr_i[8] && (haddr_i[7:2] == `GPX_IDX_STATUS);
   wire rd_data = acc && !hwrite_i && !dec_now[6] && !dec_now[5] && dec_now[1:0] == `GPX_K0_DATA;
   wire pin_hold;
   reg first_r;

   // Zero-wait slave, every answer is OKAY
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;

   // ==========================================================
   // Reset-release timers
   // Catch the power-on strap on the first edge after release
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         first_r <= 1'b1;
      end else begin
         first_r <= 1'b0;
      end
   end

   // Pin hold runs on any reset release
   // A test-mode reset and a power-on reset look the same to this timer,
   // so the pad is held low after every release
   gpx_hold_timer #(
      .CNT_W(`GPX_CNT_W),
      .CYCLES(PIN_HOLD_CYC)
   ) u_pin_hold (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .cancel_i(1'b0),
      .busy_o(pin_hold)
   );

   // CPU hold only after power-on; it outlasts the pin hold, hiding it
   gpx_hold_timer #(
      .CNT_W(`GPX_CNT_W),
      .CYCLES(CPU_HOLD_CYC)
   ) u_cpu_hold (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .cancel_i(first_r && !por_reset_i),
      .busy_o(cpu_hold_o)
   );

   // ==========================================================
   // Bus address phase capture
   // Decode is kept beside the pending flag: hwdata comes a cycle later,
   // when haddr may already name the next transfer
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_pend_r <= 1'b0;
         wr_dec_r <= 7'h7f;
      end else begin
         wr_pend_r <= acc && hwrite_i && !dec_now[6];
         wr_dec_r <= dec_now;
      end
   end

   // Read data is registered at the address edge, so it stands in the data phase
   // Bits 31:8 always read zero; a status read fills only its low three bits
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         hrdata_o <= 32'h00000000;
      end else if (acc && !hwrite_i) begin
         hrdata_o <= 32'h00000000;
         if (stat_hit) begin
            hrdata_o[`GPX_ST_PIN_HOLD] <= pin_hold;
            hrdata_o[`GPX_ST_CPU_HOLD] <= cpu_hold_o;
            hrdata_o[`GPX_ST_IRQ] <= pin_irq_o;
         end else if (rd_data && !dec_now[5]) begin
            // Live pin levels, not the stored outputs
            hrdata_o[7:0] <= pins[dec_now[4:2]*8 +: 8];
         end
      end
   end

   // ==========================================================
   // Register writes; all other registers are write only and read zero
   // Writes land even while the hold pin is forced, so nothing is lost
   // A narrow-port write stores eight bits; the pad mask hides the upper four
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         data_r <= {`GPX_NPIN{1'b0}};
         inten_r <= {`GPX_NPIN{1'b0}};
         glbsel_r <= {`GPX_NPIN{1'b0}};
         drv_lo_r <= {`GPX_NPIN{1'b0}};
         drv_hi_r <= {`GPX_NPIN{1'b0}};
         intctl0_r <= {`GPX_NPIN{1'b0}};
         intctl1_r <= {`GPX_NPIN{1'b0}};
      end else if (wr_pend_r) begin
         if (!wr_dec_r[5]) begin
            case (wr_dec_r[1:0])
               `GPX_K0_DATA: data_r[wr_dec_r[4:2]*8 +: 8] <= hwdata_i[7:0];
               `GPX_K0_INTEN: inten_r[wr_dec_r[4:2]*8 +: 8] <= hwdata_i[7:0];
               `GPX_K0_GLBSEL: glbsel_r[wr_dec_r[4:2]*8 +: 8] <= hwdata_i[7:0];
               default: data_r <= data_r;
            endcase
         end else begin
            // Bank 1: drive and interrupt mode, writable during the hold
            case (wr_dec_r[1:0])
               `GPX_K1_DRV_LO: drv_lo_r[wr_dec_r[4:2]*8 +: 8] <= hwdata_i[7:0];
               `GPX_K1_DRV_HI: drv_hi_r[wr_dec_r[4:2]*8 +: 8] <= hwdata_i[7:0];
               `GPX_K1_INTCTL0: intctl0_r[wr_dec_r[4:2]*8 +: 8] <= hwdata_i[7:0];
               `GPX_K1_INTCTL1: intctl1_r[wr_dec_r[4:2]*8 +: 8] <= hwdata_i[7:0];
               default: drv_lo_r <= drv_lo_r;
            endcase
         end
      end
   end

   // ==========================================================
   // Pin history for edge and change detection
   // Change mode compares with what the CPU last saw of that port
   // Reset level zero is harmless: interrupt enables also come up cleared
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prev_pin_r <= {`GPX_NPIN{1'b0}};
         last_rd_r <= {`GPX_NPIN{1'b0}};
      end else begin
         prev_pin_r <= pins;
         if (rd_data) begin
            last_rd_r[dec_now[4:2]*8 +: 8] <= pins[dec_now[4:2]*8 +: 8];
         end
      end
   end

   // ==========================================================
   // Per-pin drive, global routing and event logic
   wire [`GPX_NPIN-1:0] out_nxt;
   wire [`GPX_NPIN-1:0] oen_nxt;
   wire [`GPX_NPIN-1:0] pu_nxt;
   wire [`GPX_NPIN-1:0] pd_nxt;
   wire [`GPX_NPIN-1:0] glb_drv;
   wire [`GPX_NPIN-1:0] evt;

   genvar gi;
   generate
      for (gi = 0; gi < `GPX_NPIN; gi = gi + 1) begin : g_pin
         wire [1:0] dm = {drv_hi_r[gi], drv_lo_r[gi]};
         wire hiz = (dm == `GPX_DM_HIZ);
         // Global receive replaces the CPU data bit as the drive source
         wire src = (glbsel_r[gi] && !hiz) ? glb_out_i[gi % `GPX_GLB_W] : data_r[gi];
         wire [2:0] drv = drv_decode(dm, src);
         wire [1:0] im = {intctl1_r[gi], intctl0_r[gi]};
         wire rise = pins[gi] && !prev_pin_r[gi];
         wire fall = !pins[gi] && prev_pin_r[gi];
         reg hit;
         if (gi == `GPX_HOLD_PIN) begin : g_hold
            // Forced strong low; input path and settings untouched
            // Only the pad side is overridden: data_r keeps what software wrote,
            // and the stored level appears on the first edge after the hold
            assign out_nxt[gi] = pin_hold ? 1'b0 : src;
            assign oen_nxt[gi] = pin_hold ? 1'b0 : !drv[2];
            assign pu_nxt[gi] = pin_hold ? 1'b0 : drv[1];
            assign pd_nxt[gi] = pin_hold ? 1'b0 : drv[0];
         end else begin : g_norm
            assign out_nxt[gi] = src;
            assign oen_nxt[gi] = !drv[2];
            assign pu_nxt[gi] = drv[1];
            assign pd_nxt[gi] = drv[0];
         end
         // High-Z plus global select feeds the pin onto the global input line
         assign glb_drv[gi] = glbsel_r[gi] && hiz && pins[gi];
         // Mode pair {high, low}: 00 change from last read, 01 rise, 10 fall, 11 both
         // Change mode is a level: it stays up while the pin differs from the level software last read
         // Edge modes last one cycle; there is no sticky flag to clear
         always @* begin
            case (im)
               `GPX_IM_CHANGE: hit = pins[gi] != last_rd_r[gi];
               `GPX_IM_RISE: hit = rise;
               `GPX_IM_FALL: hit = fall;
               `GPX_IM_BOTH: hit = rise || fall;
               default: hit = 1'b0;
            endcase
         end
         assign evt[gi] = hit && inten_r[gi];
      end
   endgenerate

   // Merge pins of equal bit index onto each global input line
   // Pins of different ports share a line and are OR-ed, so software
   // should route one pin per line for a clean signal
   reg [`GPX_GLB_W-1:0] glb_nxt;
   integer pi;
   always @* begin
      glb_nxt = {`GPX_GLB_W{1'b0}};
      for (pi = 0; pi < `GPX_NPIN; pi = pi + 1) begin
         glb_nxt[pi % `GPX_GLB_W] = glb_nxt[pi % `GPX_GLB_W] | glb_drv[pi];
      end
   end

   // ==========================================================
   // Output registers; absent narrow-port bits stay undriven
   // Registering costs one cycle of pin latency but keeps pads glitch free
   // Absent pads keep the enable high and no pull, so they never fight the board
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pin_out_o <= {`GPX_NPIN{1'b0}};
         pin_oen_o <= {`GPX_NPIN{1'b1}};
         pin_pullup_o <= {`GPX_NPIN{1'b0}};
         pin_pulldown_o <= {`GPX_NPIN{1'b0}};
         glb_in_o <= {`GPX_GLB_W{1'b0}};
         pin_irq_o <= 1'b0;
      end else begin
         pin_out_o <= out_nxt & `GPX_PIN_MASK;
         pin_oen_o <= oen_nxt | ~`GPX_PIN_MASK;
         pin_pullup_o <= pu_nxt & `GPX_PIN_MASK;
         pin_pulldown_o <= pd_nxt & `GPX_PIN_MASK;
         glb_in_o <= glb_nxt;
         pin_irq_o <= |(evt & `GPX_PIN_MASK);
      end
   end

   // The board must keep port 2 pins 4 and 6 low in sleep; nothing here enforces it
endmodule

// >>> tb_general_purpose_io_ports.sv
// Self-checking bench for the GPIO port block, registers reached over AHB-Lite.
// Assumes the board model on the pins and shortened hold counts.
`timescale 1ns/1ps
module tb_general_purpose_io_ports;
   localparam PH = 20;
   localparam CH = 40;
   reg clk_i = 1'b0;
   reg rstn_i = 1'b0;
   reg por = 1'b1;
   reg hsel = 1'b0;
   reg hwrite = 1'b0;
   reg [1:0] htrans = 2'h0;
   reg [31:0] haddr = 32'h0;
   reg [31:0] hwdata = 32'h0;
   reg [31:0] rd;
   reg [7:0] glb_out = 8'h00;
   reg [7:0] lo, hi;
   reg [47:0] ext_en = 48'h0;
   reg [47:0] ext_val = 48'h0;
   reg got;
   integer m;
   integer fail_count = 0;
   integer n_tests = 0;
   wire hready, hresp, irq, cpu_hold;
   wire [31:0] hrdata;
   wire [7:0] glb_in;
   wire [47:0] pin_in, pout, poen, ppu, ppd;
   // ==========
   // Design, board and clock
   gpx_top #(.PIN_HOLD_CYC(PH), .CPU_HOLD_CYC(CH)) uut (.clk_i(clk_i), .rstn_i(rstn_i), .por_reset_i(por),
      .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .pin_in_i(pin_in),
      .pin_out_o(pout), .pin_oen_o(poen), .pin_pullup_o(ppu), .pin_pulldown_o(ppd), .glb_out_i(glb_out),
      .glb_in_o(glb_in), .pin_irq_o(irq), .cpu_hold_o(cpu_hold));
   gpx_board u_board (.clk_i(clk_i), .pin_out_i(pout), .pin_oen_i(poen), .pin_pu_i(ppu), .pin_pd_i(ppd),
      .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_o(pin_in));
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   // ==========
   // Bus and compare tasks
   function [31:0] ra(input [2:0] p, input b, input [1:0] k);
      ra = {23'h0, b, 1'b0, p, k, 2'h0};
   endfunction
   // Expected {oen, pullup, pulldown, driven level} of one port
   function [31:0] drv(input [7:0] d, input [7:0] l, input [7:0] h);
      integer i;
      begin
         drv = 32'h0;
         for (i = 0; i < 8; i = i + 1) begin
            drv[24+i] = (h[i] & !l[i]) | (!h[i] & !l[i] & !d[i]) | (h[i] & l[i] & d[i]);
            drv[16+i] = h[i] & l[i] & d[i];
            drv[8+i] = !h[i] & !l[i] & !d[i];
            drv[i] = d[i] & !drv[24+i];
         end
      end
   endfunction
   task cyc(input integer n);
      repeat (n) @(posedge clk_i);
   endtask
   // Address phase held until ready, then data phase until ready
   task bus(input w, input [31:0] a, input [7:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge clk_i);
      while (hready !== 1'b1) @(posedge clk_i);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      @(posedge clk_i);
      while (hready !== 1'b1) @(posedge clk_i);
      rd = hrdata;
   endtask
   task wr(input [31:0] a, input [7:0] d);
      bus(1'b1, a, d);
   endtask
   task chk(input string nm, input [47:0] e, input [47:0] g);
      n_tests = n_tests + 1;
      if (g !== e) begin
         fail_count = fail_count + 1;
         $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
   endtask
   task rd_chk(input string nm, input [31:0] a, input [31:0] e);
      bus(1'b0, a, 8'h00);
      chk(nm, e, rd);
   endtask
   // Irq seen within four cycles of a pin edge
   task pulse_chk(input v, input e);
      ext_val[32] <= v;
      got = 1'b0;
      repeat (4) @(negedge clk_i) got = got | irq;
      chk("irq edge", e, got);
      @(posedge clk_i);
   endtask
   task done(input string s);
      $display("test %0s done", s);
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ==========
   // Tests
   initial begin
      cyc(8);
      chk("rst oen", {48{1'b1}}, poen);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      wr(ra(1, 1, 0), 8'h01);
      wr(ra(1, 0, 0), 8'h01);
      rd_chk("status", 32'h60, 32'h3);
      chk("held pin", 2'h0, {poen[8], pout[8]});
      cyc(PH + CH);
      chk("freed pin", 2'h1, {poen[8], pout[8]});
      rd_chk("status", 32'h60, 32'h0);
      done("hold");
      // Mixed low bits give each pin its own direction
      for (m = 0; m < 4; m = m + 1) begin
         lo = m[0] ? 8'hf0 : 8'h0f;
         hi = {8{m[1]}};
         wr(ra(0, 1, 0), lo);
         wr(ra(0, 1, 1), hi);
         wr(ra(0, 0, 0), 8'h33);
         cyc(3);
         chk("drive", drv(8'h33, lo, hi), {poen[7:0], ppu[7:0], ppd[7:0], pout[7:0] & ~poen[7:0]});
      end
      done("drive");
      ext_en <= 48'hff01ff000000;
      ext_val <= 48'hff00a5000000;
      cyc(2);
      rd_chk("port3", ra(3, 0, 0), 32'ha5);
      rd_chk("port5", ra(5, 0, 0), 32'h0f);
      rd_chk("wo reg", ra(3, 0, 1), 32'h0);
      rd_chk("wo drive", ra(0, 1, 0), 32'h0);
      rd_chk("unmapped", 32'h1fc, 32'h0);
      done("access");
      wr(ra(4, 0, 1), 8'h01);
      for (m = 1; m < 4; m = m + 1) begin
         wr(ra(4, 1, 2), {7'h0, m[0]});
         wr(ra(4, 1, 3), {7'h0, m[1]});
         cyc(2);
         pulse_chk(1'b1, m[0]);
         pulse_chk(1'b0, m[1]);
      end
      wr(ra(4, 0, 1), 8'h00);
      pulse_chk(1'b1, 1'b0);
      pulse_chk(1'b0, 1'b0);
      wr(ra(4, 1, 2), 8'h00);
      wr(ra(4, 1, 3), 8'h00);
      wr(ra(4, 0, 1), 8'h01);
      rd_chk("port4", ra(4, 0, 0), 32'h0);
      ext_val[32] <= 1'b1;
      cyc(3);
      chk("irq level", 1'b1, irq);
      rd_chk("status", 32'h60, 32'h4);
      rd_chk("port4", ra(4, 0, 0), 32'h1);
      cyc(3);
      chk("irq cleared", 1'b0, irq);
      done("irq");
      ext_en[17] <= 1'b1;
      ext_val[17] <= 1'b1;
      wr(ra(2, 0, 2), 8'h02);
      wr(ra(2, 1, 1), 8'h02);
      cyc(3);
      chk("glb in", 8'h02, glb_in);
      ext_en[17] <= 1'b0;
      wr(ra(2, 1, 1), 8'h00);
      wr(ra(2, 1, 0), 8'h02);
      glb_out <= 8'h02;
      cyc(3);
      chk("glb out hi", 1'b1, pout[17]);
      glb_out <= 8'h00;
      cyc(3);
      chk("glb out lo", 1'b0, pout[17]);
      done("global");
      por <= 1'b0;
      rstn_i <= 1'b0;
      cyc(8);
      rstn_i <= 1'b1;
      cyc(3);
      chk("reset2 hold", 3'h0, {poen[8], pout[8], cpu_hold});
      chk("reset2 out", 48'h0, pout);
      done("reset2");
      report_and_stop;
   end
   // Cuts a hang short well past the expected run length
   initial begin
      #20000;
      fail_count = fail_count + 1;
      $display("[ERR] watchdog exp finish got timeout");
      report_and_stop;
   end
endmodule
